// ===== hw/synth_control_word_low_fields.sv
// low fields of the main control word: mode, update strobe, sinc, keying, serial
// assumes host writes through a word-wide programming port on the system clock
`timescale 1ns/1ns
module synth_control_word_low_fields #(
    parameter int STROBE_PERIOD = 16,
    parameter int SAMPLE_W = 12
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ctl_wr,
    input wire logic [ctl_word_pkg::CTL_W-1:0] ctl_wdata,
    output logic [ctl_word_pkg::CTL_W-1:0] ctl_rdata,
    input wire logic mult_a_wr,
    input wire logic mult_b_wr,
    input wire logic [ctl_word_pkg::KEY_MULT_W-1:0] mult_wdata,
    input wire logic [ctl_word_pkg::KEY_MULT_W-1:0] key_ramp_factor,
    input wire logic update_strobe_pin_in,
    output logic update_strobe_pin_out,
    output logic update_strobe_pin_oe,
    output logic update_pulse,
    output ctl_word_pkg::op_mode_t op_mode,
    output logic mode_valid,
    input wire logic [SAMPLE_W-1:0] core_sample,
    input wire logic [SAMPLE_W-1:0] sinc_sample,
    output logic [SAMPLE_W-1:0] keying_in,
    output logic sinc_clk_en,
    output logic key_enable,
    output logic [ctl_word_pkg::KEY_MULT_W-1:0] cos_scale,
    output logic [ctl_word_pkg::KEY_MULT_W-1:0] ctl_scale,
    output logic lsb_first,
    output logic sdo_enable
);
    import ctl_word_pkg::*;

    logic [CTL_W-1:0] ctl_r;
    logic [KEY_MULT_W-1:0] mult_a_r, mult_b_r;
    logic [15:0] div_r;
    logic strobe_r;
    logic ext_level, ext_level_d_r;
    logic [SAMPLE_W-1:0] keying_r;
    logic [KEY_MULT_W-1:0] cos_scale_r;

    // register image
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctl_r <= CTL_RESET;
        end else if (ctl_wr) begin
            ctl_r <= ctl_wdata;
        end
    end
    // reserved bits kept as written; the host is expected to write zero there
    assign ctl_rdata = ctl_r;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mult_a_r <= KEY_MULT_RESET;
            mult_b_r <= KEY_MULT_RESET;
        end else begin
            if (mult_a_wr) begin
                mult_a_r <= mult_wdata;
            end
            if (mult_b_wr) begin
                mult_b_r <= mult_wdata;
            end
        end
    end

    wire int_update = ctl_r[INT_UPDATE_BIT];
    wire sinc_bypass = ctl_r[SINC_BYPASS_BIT];
    wire key_en = ctl_r[KEY_EN_BIT];
    wire key_int = ctl_r[KEY_INT_BIT];

    mode_decode u_mode (
        .mode_field(ctl_r[MODE_LSB +: MODE_W]),
        .op_mode(op_mode),
        .mode_valid(mode_valid)
    );

    // internal update strobe: divider gives a one-cycle pulse
    wire div_end = (div_r == 16'(STROBE_PERIOD - 1));
    always_ff @(posedge clock) begin
        if (!nrst || !int_update) begin
            div_r <= 16'h0000;
            strobe_r <= 1'b0;
        end else begin
            div_r <= div_end ? 16'h0000 : div_r + 16'h0001;
            strobe_r <= div_end;
        end
    end

    pin_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(update_strobe_pin_in),
        .level(ext_level)
    );
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ext_level_d_r <= 1'b0;
        end else begin
            ext_level_d_r <= ext_level;
        end
    end
    wire ext_rise = ext_level & ~ext_level_d_r;

    assign update_strobe_pin_oe = int_update;
    assign update_strobe_pin_out = strobe_r;
    // pin ignored while driven, so our own strobe is not counted twice
    assign update_pulse = int_update ? strobe_r : ext_rise;

    // datapath selects registered
    always_ff @(posedge clock) begin
        if (!nrst) begin
            keying_r <= '0;
            cos_scale_r <= KEY_MULT_RESET;
        end else begin
            keying_r <= sinc_bypass ? core_sample : sinc_sample;
            // disabled keying passes full scale is not assumed: zero until enabled
            cos_scale_r <= !key_en ? KEY_MULT_RESET :
                           key_int ? key_ramp_factor : mult_a_r;
        end
    end
    assign keying_in = keying_r;
    assign cos_scale = cos_scale_r;
    assign ctl_scale = mult_b_r;
    assign sinc_clk_en = ~sinc_bypass;
    assign key_enable = key_en;
    assign lsb_first = ctl_r[LSB_FIRST_BIT];
    assign sdo_enable = ctl_r[SDO_EN_BIT];
endmodule

// ===== inc/ctl_word_pkg.sv
// package for the low control word field decoder
// assumes a 32-bit control word written by a programming port
package ctl_word_pkg;
    localparam int CTL_W = 32;
    localparam int MODE_LSB = 9;
    localparam int MODE_W = 3;
    localparam int INT_UPDATE_BIT = 8;
    localparam int RSVD7_BIT = 7;
    localparam int SINC_BYPASS_BIT = 6;
    localparam int KEY_EN_BIT = 5;
    localparam int KEY_INT_BIT = 4;
    localparam int RSVD_LO_LSB = 2;
    localparam int LSB_FIRST_BIT = 1;
    localparam int SDO_EN_BIT = 0;
    localparam int KEY_MULT_W = 12;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [11:0] KEY_MULT_RESET = 12'h000;
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_FSK = 3'h1;
    localparam logic [2:0] MODE_RAMP_FSK = 3'h2;
    localparam logic [2:0] MODE_CHIRP = 3'h3;
    localparam logic [2:0] MODE_BPSK = 3'h4;
    typedef enum logic [2:0] {
        op_single, op_fsk, op_ramp_fsk, op_chirp, op_bpsk, op_undef
    } op_mode_t;
endpackage

// ===== hw/pin_sync.sv
// three-stage synchroniser with agreement of stages two and three
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ns
module pin_sync (
    input wire logic clock,
    input wire logic nrst,
    input wire logic async_in,
    output logic level
);
    logic s1_r, s2_r, s3_r, level_r;
    assign level = level_r;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule

// ===== hw/mode_decode.sv
// enumerated decode of the three-bit operating mode field
// assumes field comes from a register on the same clock
`timescale 1ns/1ns
module mode_decode (
    input wire logic [ctl_word_pkg::MODE_W-1:0] mode_field,
    output ctl_word_pkg::op_mode_t op_mode,
    output logic mode_valid
);
    import ctl_word_pkg::*;
    // codes above bpsk have no mode; flagged, decoded as op_undef
    assign mode_valid = (mode_field <= MODE_BPSK);
    assign op_mode = (mode_field == MODE_SINGLE) ? op_single :
                     (mode_field == MODE_FSK) ? op_fsk :
                     (mode_field == MODE_RAMP_FSK) ? op_ramp_fsk :
                     (mode_field == MODE_CHIRP) ? op_chirp :
                     (mode_field == MODE_BPSK) ? op_bpsk : op_undef;
endmodule

// ===== testbench/scw_checker.sv
// assertions on the control word field decoder ports
// assumes bind onto the decoder top with default strobe period
`timescale 1ns/1ns
module scw_checker (
    input wire logic clock, nrst, ctl_wr, update_strobe_pin_out, update_strobe_pin_oe, update_pulse,
    input wire logic mode_valid, sinc_clk_en, key_enable, lsb_first, sdo_enable,
    input wire logic [31:0] ctl_wdata, ctl_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_wr; ctl_wr |=> ctl_rdata == $past(ctl_wdata); endproperty
    a_wr: assert property (p_wr) else $error("word not stored");
    property p_rst; $rose(nrst) |-> ctl_rdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("bad reset word");
    property p_oe; update_strobe_pin_oe == ctl_rdata[8]; endproperty
    a_oe: assert property (p_oe) else $error("bad pin enable");
    // period of sixteen leaves eight quiet edges at least
    property p_gap; update_strobe_pin_out |=> !update_strobe_pin_out [*8]; endproperty
    a_gap: assert property (p_gap) else $error("strobe too close");
    property p_ext; !update_strobe_pin_oe |-> !update_strobe_pin_out; endproperty
    a_ext: assert property (p_ext) else $error("strobe while input");
    property p_sinc; sinc_clk_en != ctl_rdata[6]; endproperty
    a_sinc: assert property (p_sinc) else $error("bad filter clock");
    property p_key; key_enable == ctl_rdata[5]; endproperty
    a_key: assert property (p_key) else $error("bad keying enable");
    property p_ser; {lsb_first, sdo_enable} == ctl_rdata[1:0]; endproperty
    a_ser: assert property (p_ser) else $error("bad serial bits");
    property p_mv; mode_valid == (ctl_rdata[11:9] < 3'h5); endproperty
    a_mv: assert property (p_mv) else $error("bad mode flag");
    c_int: cover property (update_strobe_pin_out);
    c_ext: cover property (!update_strobe_pin_oe && update_pulse);
    c_byp: cover property (!sinc_clk_en);
endmodule

// ===== testbench/strobe_host.sv
// host side of the update strobe pin
// assumes the bench resolves the pin from the device enable
`timescale 1ns/1ns
module strobe_host (
    input wire logic clock,
    input wire logic fire,
    output logic pin_lvl
);
    int n = 0;
    initial pin_lvl = 1'h0;
    // held three edges so the synchroniser stages agree
    always @(posedge clock) begin
        n <= fire ? 3 : (n > 0 ? n - 1 : 0);
        pin_lvl <= fire || n > 1;
    end
endmodule

// ===== testbench/synth_control_word_low_fields_tb_top.sv
// bench for the control word field decoder
// assumes default strobe period of sixteen cycles
`timescale 1ns/1ns
module synth_control_word_low_fields_tb_top;
    import ctl_word_pkg::*;
    logic clock = 0, nrst = 0, ctl_wr = 0, ma = 0, mb = 0, fire = 0, p_out, oe, lvl, upd, mv, sck, ken, lsb, sdo;
    logic [31:0] wd = 0, rd;
    logic [11:0] mw = 0, ramp = 12'h5A5, core = 12'h3C3, sinc = 12'hC3C, kin, cos, csc;
    op_mode_t om;
    wire pin = oe ? p_out : lvl;
    int n_mismatch = 0, comparisons = 0, n;
    synth_control_word_low_fields u_synth_control_word_low_fields (.clock, .nrst, .ctl_wr, .ctl_wdata(wd),
        .ctl_rdata(rd), .mult_a_wr(ma), .mult_b_wr(mb), .mult_wdata(mw), .key_ramp_factor(ramp),
        .update_strobe_pin_in(pin), .update_strobe_pin_out(p_out), .update_strobe_pin_oe(oe), .update_pulse(upd),
        .op_mode(om), .mode_valid(mv), .core_sample(core), .sinc_sample(sinc), .keying_in(kin), .sinc_clk_en(sck),
        .key_enable(ken), .cos_scale(cos), .ctl_scale(csc), .lsb_first(lsb), .sdo_enable(sdo));
    strobe_host u_strobe_host (.clock, .fire, .pin_lvl(lvl));
    initial forever #5 clock = ~clock;
    task automatic chk(string s, logic [31:0] g, logic [31:0] e);
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", s, e, g);
            n_mismatch++;
        end
        comparisons++;
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(logic [31:0] d, logic a = 0, logic b = 0);
        @(posedge clock);
        ctl_wr <= !a && !b;
        ma <= a;
        mb <= b;
        wd <= d;
        mw <= d[11:0];
        @(posedge clock);
        {ctl_wr, ma, mb} <= 3'h0;
        #1;
    endtask
    // bounded wait, a hang counts as a mismatch
    task automatic wait_upd;
        n = 0;
        do begin @(posedge clock); #1; n++; end while (upd !== 1'h1 && n < 40);
        if (n >= 40) begin n_mismatch++; final_report(); end
    endtask
    task automatic t_reset;
        chk("word", rd, 32'h0);
        chk("scales", {cos, csc}, 32'h0);
        chk("serial", {lsb, sdo}, 32'h0);
        chk("filter clock", sck, 32'h1);
        chk("pin enable", oe, 32'h0);
    endtask
    task automatic t_modes;
        // host keeps to defined codes
        for (int m = 0; m < 5; m++) begin
            wr(32'(m) << 9);
            chk("mode", om, 32'(m));
            chk("mode valid", mv, 32'h1);
        end
    endtask
    // table words keep the reserved bits at zero
    logic [31:0] wd_t [4] = '{32'h20, 32'h33, 32'h41, 32'h0};
    logic [31:0] cs_t [4] = '{32'hABC, 32'h5A5, 32'h0, 32'h0};
    logic [31:0] ki_t [4] = '{32'hC3C, 32'hC3C, 32'h3C3, 32'hC3C};
    task automatic t_keying;
        wr(32'hABC, 1);
        wr(32'h123, 0, 1);
        chk("ctl scale", csc, 32'h123);
        // table of word, expected cosine scale and keying input
        foreach (wd_t[i]) begin
            wr(wd_t[i]);
            @(posedge clock); #1;
            chk("cos scale", cos, cs_t[i]);
            chk("keying in", kin, ki_t[i]);
            chk("serial", {lsb, sdo}, wd_t[i][1:0]);
        end
    endtask
    task automatic t_strobe;
        wr(32'h100);
        chk("pin enable", oe, 32'h1);
        wait_upd();
        chk("first strobe", n, 32'd16);
        chk("pin out", p_out, 32'h1);
        wait_upd();
        chk("strobe period", n, 32'd16);
        wr(32'h0);
        @(posedge clock);
        fire <= 1'h1;
        @(posedge clock);
        fire <= 1'h0;
        wait_upd();
        chk("ext strobe", n, 32'd4);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'h1;
        @(posedge clock); #1;
        t_reset();
        t_modes();
        t_keying();
        t_strobe();
        final_report();
    end
endmodule
bind synth_control_word_low_fields scw_checker u_scw_checker (.clock, .nrst, .ctl_wr, .update_strobe_pin_out,
    .update_strobe_pin_oe, .update_pulse, .mode_valid, .sinc_clk_en, .key_enable, .lsb_first, .sdo_enable,
    .ctl_wdata, .ctl_rdata);
